//--- design/pic_map.svh
// Register offsets, field positions, reset values and sizes
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH

`define PIC_N_SRC        32
`define PIC_N_SLOT       16
`define PIC_ADDR_W       12
`define PIC_OFS_NSTAT    12'h000
`define PIC_OFS_FSTAT    12'h004
`define PIC_OFS_RAW      12'h008
`define PIC_OFS_ENABLE   12'h00C
`define PIC_OFS_SELECT   12'h010
`define PIC_OFS_SOFT     12'h014
`define PIC_OFS_VECT     12'h018
`define PIC_OFS_DEFAULT  12'h01C
`define PIC_PAGE_MISC    4'h0
`define PIC_PAGE_VADDR   4'h1
`define PIC_PAGE_VCTRL   4'h2
`define PIC_CTRL_EN_BIT  5
`define PIC_CTRL_W       6
`define PIC_RST_WORD     32'h0000_0000
`define PIC_RST_CTRL     6'h00
`define PIC_WDOG_CH      0
`define PIC_SOFT_CH      1

`endif

//--- design/pic_pkg.sv
// Types shared by the interrupt controller files
package pic_pkg;
	typedef logic [31:0] pic_word_t;
	typedef enum logic [1:0]
	{
		PIC_RESP_OKAY   = 2'h0,
		PIC_RESP_SLVERR = 2'h2
	} pic_resp_t;
endpackage

//--- design/pic_slot_select.sv
// Fixed-priority pick of the lowest numbered requesting slot
`timescale 1ns/1ps
`default_nettype none
module pic_slot_select
	import pic_pkg::*;
#(
	parameter int N_SLOT = 16
)
(
	// Slot requests
	input  wire logic [N_SLOT-1:0]         hit_in,
	// Winner
	output logic                           found_out,
	output logic [$clog2(N_SLOT)-1:0]      index_out
);
	always_comb
	begin
		found_out = 1'b0;
		index_out = '0;
		for (int i = N_SLOT - 1; i >= 0; i--)
		begin
			if (hit_in[i])
			begin
				found_out = 1'b1;
				index_out = ($clog2(N_SLOT))'(i);
			end
		end
	end
endmodule
`default_nettype wire

//--- design/pic_controller.sv
// Prioritising interrupt controller with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "pic_map.svh"
module pic_controller
	import pic_pkg::*;
#(
	parameter int N_SLOT = `PIC_N_SLOT
)
(
	// Clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	// Peripheral request lines
	input  wire logic                     watchdog_request_in,
	input  wire logic [`PIC_N_SRC-1:2]    periph_request_in,
	// Processor requests
	output logic                          fast_interrupt_request_out,
	output logic                          normal_interrupt_request_out,
	// AXI4-Lite write
	input  wire logic [`PIC_ADDR_W-1:0]   s_axi_awaddr_in,
	input  wire logic                     s_axi_awvalid_in,
	output logic                          s_axi_awready_out,
	input  wire logic [31:0]              s_axi_wdata_in,
	input  wire logic [3:0]               s_axi_wstrb_in,
	input  wire logic                     s_axi_wvalid_in,
	output logic                          s_axi_wready_out,
	output logic [1:0]                    s_axi_bresp_out,
	output logic                          s_axi_bvalid_out,
	input  wire logic                     s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [`PIC_ADDR_W-1:0]   s_axi_araddr_in,
	input  wire logic                     s_axi_arvalid_in,
	output logic                          s_axi_arready_out,
	output logic [31:0]                   s_axi_rdata_out,
	output logic [1:0]                    s_axi_rresp_out,
	output logic                          s_axi_rvalid_out,
	input  wire logic                     s_axi_rready_in
);
	localparam int IW = $clog2(N_SLOT);
	localparam int SW = IW + 1;
	localparam logic [SW-1:0] SERVE_NONE = SW'(N_SLOT);

	////////////////////////////////////////////////////////////////////
	// State
	pic_word_t                en_reg, en_next;
	pic_word_t                sel_reg, sel_next;
	pic_word_t                soft_reg, soft_next;
	pic_word_t                def_reg, def_next;
	pic_word_t                vaddr_reg [N_SLOT];
	pic_word_t                vaddr_next [N_SLOT];
	logic [`PIC_CTRL_W-1:0]   vctrl_reg [N_SLOT];
	logic [`PIC_CTRL_W-1:0]   vctrl_next [N_SLOT];
	logic [SW-1:0]            serve_reg, serve_next;
	logic                     fast_reg, fast_next;
	logic                     norm_reg, norm_next;
	logic                     wr_rdy_reg, wr_rdy_next;
	logic                     bvalid_reg, bvalid_next;
	pic_resp_t                bresp_reg, bresp_next;
	logic                     ar_rdy_reg, ar_rdy_next;
	logic                     rvalid_reg, rvalid_next;
	pic_resp_t                rresp_reg, rresp_next;
	pic_word_t                rdata_reg, rdata_next;

	pic_word_t                raw;
	pic_word_t                fast_pend;
	pic_word_t                norm_pend;
	logic [N_SLOT-1:0]        slot_hit;
	logic                     slot_found;
	logic [IW-1:0]            slot_idx;
	pic_word_t                vect_value;
	logic                     wr_hs;
	logic                     rd_hs;
	pic_word_t                wmask;
	pic_word_t                rd_val;
	logic                     rd_err;
	logic                     wr_err;

	////////////////////////////////////////////////////////////////////
	// Request sorting
	// Channel 1 has no hardware line; software bits may raise any
	assign raw = {periph_request_in, 1'b0, watchdog_request_in}
		| soft_reg;
	assign fast_pend = raw & en_reg & sel_reg;
	assign norm_pend = raw & en_reg & ~sel_reg;

	genvar g;
	generate
		for (g = 0; g < N_SLOT; g++)
		begin : g_slot
			// Slots numbered at or above the one in service are held back
			assign slot_hit[g] = vctrl_reg[g][`PIC_CTRL_EN_BIT]
				& norm_pend[vctrl_reg[g][4:0]]
				& (SW'(g) < serve_reg);
		end
	endgenerate

	pic_slot_select #(
		.N_SLOT    (N_SLOT)
	) u_select (
		.hit_in    (slot_hit),
		.found_out (slot_found),
		.index_out (slot_idx)
	);

	assign vect_value = slot_found ? vaddr_reg[slot_idx] : def_reg;

	////////////////////////////////////////////////////////////////////
	// Bus decode
	assign wr_hs = wr_rdy_reg & s_axi_awvalid_in & s_axi_wvalid_in;
	assign rd_hs = ar_rdy_reg & s_axi_arvalid_in;
	assign wmask = {{8{s_axi_wstrb_in[3]}}, {8{s_axi_wstrb_in[2]}},
		{8{s_axi_wstrb_in[1]}}, {8{s_axi_wstrb_in[0]}}};

	function automatic pic_word_t merge(pic_word_t old, pic_word_t nw,
		pic_word_t m);
		merge = (old & ~m) | (nw & m);
	endfunction

	always_comb
	begin
		logic [`PIC_ADDR_W-1:0] a;
		a = s_axi_araddr_in;
		rd_val = `PIC_RST_WORD;
		rd_err = 1'b0;
		unique case (a[11:8])
			`PIC_PAGE_MISC:
				unique case (a)
					`PIC_OFS_NSTAT:   rd_val = norm_pend;
					`PIC_OFS_FSTAT:   rd_val = fast_pend;
					`PIC_OFS_RAW:     rd_val = raw;
					`PIC_OFS_ENABLE:  rd_val = en_reg;
					`PIC_OFS_SELECT:  rd_val = sel_reg;
					`PIC_OFS_SOFT:    rd_val = soft_reg;
					`PIC_OFS_VECT:    rd_val = vect_value;
					`PIC_OFS_DEFAULT: rd_val = def_reg;
					default:          rd_err = 1'b1;
				endcase
			`PIC_PAGE_VADDR:
				if (a[7:2] < 6'(N_SLOT))
					rd_val = vaddr_reg[a[2+IW-1:2]];
				else
					rd_err = 1'b1;
			`PIC_PAGE_VCTRL:
				if (a[7:2] < 6'(N_SLOT))
					rd_val = {26'h0, vctrl_reg[a[2+IW-1:2]]};
				else
					rd_err = 1'b1;
			default: rd_err = 1'b1;
		endcase
	end

	always_comb
	begin
		logic [`PIC_ADDR_W-1:0] a;
		a = s_axi_awaddr_in;
		wr_err = 1'b0;
		unique case (a[11:8])
			`PIC_PAGE_MISC:  wr_err = a > `PIC_OFS_DEFAULT;
			`PIC_PAGE_VADDR: wr_err = a[7:2] >= 6'(N_SLOT);
			`PIC_PAGE_VCTRL: wr_err = a[7:2] >= 6'(N_SLOT);
			default:         wr_err = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Bus handshake
	always_comb
	begin
		wr_rdy_next = s_axi_awvalid_in & s_axi_wvalid_in & ~wr_rdy_reg
			& ~bvalid_reg;
		bvalid_next = bvalid_reg & ~s_axi_bready_in;
		bresp_next = bresp_reg;
		if (wr_hs)
		begin
			bvalid_next = 1'b1;
			bresp_next = wr_err ? PIC_RESP_SLVERR : PIC_RESP_OKAY;
		end
		ar_rdy_next = s_axi_arvalid_in & ~ar_rdy_reg & ~rvalid_reg;
		rvalid_next = rvalid_reg & ~s_axi_rready_in;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (rd_hs)
		begin
			rvalid_next = 1'b1;
			rresp_next = rd_err ? PIC_RESP_SLVERR : PIC_RESP_OKAY;
			rdata_next = rd_val;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			wr_rdy_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= PIC_RESP_OKAY;
			ar_rdy_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg  <= PIC_RESP_OKAY;
			rdata_reg  <= `PIC_RST_WORD;
		end
		else
		begin
			wr_rdy_reg <= wr_rdy_next;
			bvalid_reg <= bvalid_next;
			bresp_reg  <= bresp_next;
			ar_rdy_reg <= ar_rdy_next;
			rvalid_reg <= rvalid_next;
			rresp_reg  <= rresp_next;
			rdata_reg  <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Configuration and request outputs
	always_comb
	begin
		logic [`PIC_ADDR_W-1:0] a;
		a = s_axi_awaddr_in;
		en_next = en_reg;
		sel_next = sel_reg;
		soft_next = soft_reg;
		def_next = def_reg;
		vaddr_next = vaddr_reg;
		vctrl_next = vctrl_reg;
		serve_next = serve_reg;
		if (rd_hs && s_axi_araddr_in == `PIC_OFS_VECT && slot_found)
			serve_next = SW'(slot_idx);
		if (wr_hs && !wr_err)
		begin
			unique case (a[11:8])
				`PIC_PAGE_MISC:
					unique case (a)
						`PIC_OFS_ENABLE:
							en_next = merge(en_reg, s_axi_wdata_in, wmask);
						`PIC_OFS_SELECT:
							sel_next = merge(sel_reg, s_axi_wdata_in,
								wmask);
						`PIC_OFS_SOFT:
							soft_next = merge(soft_reg, s_axi_wdata_in,
								wmask);
						`PIC_OFS_VECT:
							serve_next = SERVE_NONE;
						`PIC_OFS_DEFAULT:
							def_next = merge(def_reg, s_axi_wdata_in, wmask);
						default:
							en_next = en_reg;
					endcase
				`PIC_PAGE_VADDR:
					vaddr_next[a[2+IW-1:2]] = merge(vaddr_reg[a[2+IW-1:2]],
						s_axi_wdata_in, wmask);
				default:
					vctrl_next[a[2+IW-1:2]] = `PIC_CTRL_W'(merge(
						{26'h0, vctrl_reg[a[2+IW-1:2]]},
						s_axi_wdata_in, wmask));
			endcase
		end
		fast_next = |fast_pend;
		norm_next = |norm_pend;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			en_reg    <= `PIC_RST_WORD;
			sel_reg   <= `PIC_RST_WORD;
			soft_reg  <= `PIC_RST_WORD;
			def_reg   <= `PIC_RST_WORD;
			serve_reg <= SERVE_NONE;
			fast_reg  <= 1'b0;
			norm_reg  <= 1'b0;
			for (int i = 0; i < N_SLOT; i++)
			begin
				vaddr_reg[i] <= `PIC_RST_WORD;
				vctrl_reg[i] <= `PIC_RST_CTRL;
			end
		end
		else
		begin
			en_reg    <= en_next;
			sel_reg   <= sel_next;
			soft_reg  <= soft_next;
			def_reg   <= def_next;
			serve_reg <= serve_next;
			fast_reg  <= fast_next;
			norm_reg  <= norm_next;
			vaddr_reg <= vaddr_next;
			vctrl_reg <= vctrl_next;
		end
	end

	assign fast_interrupt_request_out   = fast_reg;
	assign normal_interrupt_request_out = norm_reg;
	assign s_axi_awready_out            = wr_rdy_reg;
	assign s_axi_wready_out             = wr_rdy_reg;
	assign s_axi_bvalid_out             = bvalid_reg;
	assign s_axi_bresp_out              = bresp_reg;
	assign s_axi_arready_out            = ar_rdy_reg;
	assign s_axi_rvalid_out             = rvalid_reg;
	assign s_axi_rresp_out              = rresp_reg;
	assign s_axi_rdata_out              = rdata_reg;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	fast_merge_a: assert property ((|fast_pend) |=> fast_interrupt_request_out)
		else $error("fast request not raised");
	fast_drop_a: assert property (!(|fast_pend) |=> !fast_interrupt_request_out)
		else $error("fast request without source");
	norm_merge_a: assert property ((|norm_pend) |=> normal_interrupt_request_out)
		else $error("normal request not raised");
	class_split_a: assert property (slot_found |-> !sel_reg[vctrl_reg[slot_idx][4:0]] && en_reg[vctrl_reg[slot_idx][4:0]])
		else $error("vector slot outside normal class");
	disabled_quiet_a: assert property ((en_reg == `PIC_RST_WORD) |=> !fast_interrupt_request_out && !normal_interrupt_request_out)
		else $error("disabled source drove output");
	slot_zero_a: assert property (slot_hit[0] |-> slot_found && slot_idx == '0)
		else $error("slot 0 lost priority");
	vect_read_a: assert property ((rd_hs && s_axi_araddr_in == `PIC_OFS_VECT) |=> s_axi_rvalid_out && s_axi_rdata_out == $past(vect_value))
		else $error("wrong vector address");
	default_read_a: assert property ((rd_hs && s_axi_araddr_in == `PIC_OFS_VECT && !slot_found) |=> s_axi_rdata_out == $past(def_reg))
		else $error("default address not returned");
	fast_status_a: assert property ((rd_hs && s_axi_araddr_in == `PIC_OFS_FSTAT) |=> s_axi_rdata_out == $past(fast_pend))
		else $error("fast status wrong");
	norm_status_a: assert property ((rd_hs && s_axi_araddr_in == `PIC_OFS_NSTAT) |=> s_axi_rdata_out == $past(norm_pend))
		else $error("normal status wrong");
	soft_chan_a: assert property ((soft_reg[`PIC_SOFT_CH] && en_reg[`PIC_SOFT_CH]) |=> (fast_interrupt_request_out || normal_interrupt_request_out))
		else $error("software channel request lost");
	serve_end_a: assert property ((wr_hs && !wr_err && s_axi_awaddr_in == `PIC_OFS_VECT) |=> serve_reg == SERVE_NONE)
		else $error("service not ended");
	sel_write_a: assert property ((wr_hs && s_axi_awaddr_in == `PIC_OFS_SELECT && s_axi_wstrb_in == 4'hF) |=> sel_reg == $past(s_axi_wdata_in))
		else $error("class update lost");
	bresp_hold_a: assert property ((s_axi_bvalid_out && !s_axi_bready_in) |=> s_axi_bvalid_out)
		else $error("write response dropped");

	both_req_c: cover property (fast_interrupt_request_out && normal_interrupt_request_out);
	vect_hit_c: cover property (rd_hs && s_axi_araddr_in == `PIC_OFS_VECT && slot_found);
	vect_def_c: cover property (rd_hs && s_axi_araddr_in == `PIC_OFS_VECT && !slot_found && (|norm_pend));
endmodule
`default_nettype wire

//--- tb/pic_core_model.sv
// Processor core model taking the fast and normal requests
`timescale 1ns/1ps
`default_nettype none
module pic_core_model
	import pic_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Requests from the controller
	input  wire logic       fast_in,
	input  wire logic       normal_in,
	// Entry taken: 2 fast, 1 normal, 0 idle
	output logic [1:0]      taken_out
);
	logic [1:0] taken_reg;
	logic [1:0] taken_next;

	// Fast entry wins when both lines stand
	always_comb
	begin
		taken_next = fast_in ? 2'h2 : {1'b0, normal_in};
		if (!rst_n_in)
			taken_next = 2'h0;
	end

	always_ff @(posedge clk_in)
		taken_reg <= taken_next;

	assign taken_out = taken_reg;
endmodule
`default_nettype wire

//--- tb/pic_controller_tb.sv
// Self-checking bench for the prioritising interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "pic_map.svh"
module pic_controller_tb import pic_pkg::*;;
	logic        clk_in, rst_n_in, wd, fast, norm;
	logic [31:2] per;
	logic [1:0]  taken, bresp, rresp;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	integer      errors, tests_run, seed;
	logic [31:0] en_m, sel_m, soft_m, def_m;
	logic [31:0] adr_m [16];
	logic [4:0]  src_m [16];
	logic        on_m [16];

	pic_controller pic_controller_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.watchdog_request_in(wd), .periph_request_in(per),
		.fast_interrupt_request_out(fast), .normal_interrupt_request_out(norm),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready));

	pic_core_model pic_core_model_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.fast_in(fast), .normal_in(norm), .taken_out(taken));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] raw_f();
		return {per, 1'b0, wd} | soft_m;
	endfunction

	// Best enabled normal-class slot, else the shared default
	function automatic logic [31:0] vec_f();
		logic [31:0] act;
		act = raw_f() & en_m & ~sel_m;
		for (int i = 0; i < 16; i++)
			if (on_m[i] && act[src_m[i]])
				return adr_m[i];
		return def_m;
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_p, w_p;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aw_p = 1'b1;
		w_p = 1'b1;
		while (aw_p || w_p)
		begin
			@(posedge clk_in);
			if (awready === 1'b1)
				aw_p = 1'b0;
			if (wready === 1'b1)
				w_p = 1'b0;
			awvalid <= aw_p;
			wvalid <= w_p;
		end
		bready <= 1'b1;
		do
		begin
			@(posedge clk_in);
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge clk_in);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do
		begin
			@(posedge clk_in);
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	task automatic apply();
		logic [1:0] r;
		wr(`PIC_OFS_ENABLE, en_m, r);
		wr(`PIC_OFS_SELECT, sel_m, r);
		wr(`PIC_OFS_SOFT, soft_m, r);
		wr(`PIC_OFS_DEFAULT, def_m, r);
		for (int i = 0; i < 16; i++)
		begin
			wr({`PIC_PAGE_VADDR, 2'h0, 4'(i), 2'h0}, adr_m[i], r);
			wr({`PIC_PAGE_VCTRL, 2'h0, 4'(i), 2'h0}, {26'h0, on_m[i], src_m[i]}, r);
		end
	endtask

	task automatic verify();
		logic [31:0] act;
		logic [1:0]  ex;
		logic [1:0]  r;
		repeat (3) @(posedge clk_in);
		act = raw_f() & en_m;
		ex = |(act & sel_m) ? 2'h2 : {1'b0, |(act & ~sel_m)};
		chk({31'h0, fast}, {31'h0, |(act & sel_m)});
		chk({31'h0, norm}, {31'h0, |(act & ~sel_m)});
		chk({30'h0, taken}, {30'h0, ex});
		rchk(`PIC_OFS_RAW, raw_f(), PIC_RESP_OKAY);
		rchk(`PIC_OFS_ENABLE, en_m, PIC_RESP_OKAY);
		rchk(`PIC_OFS_FSTAT, act & sel_m, PIC_RESP_OKAY);
		rchk(`PIC_OFS_NSTAT, act & ~sel_m, PIC_RESP_OKAY);
		rchk(`PIC_OFS_VECT, vec_f(), PIC_RESP_OKAY);
		wr(`PIC_OFS_VECT, 32'h0, r);
	endtask

	task automatic complete_run();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	initial
	begin
		repeat (40000) @(posedge clk_in);
		errors++;
		complete_run();
	end

	initial
	begin
		logic [1:0] r;
		seed = 40;
		errors = 0;
		tests_run = 0;
		{rst_n_in, wd, per, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, en_m, sel_m, soft_m, def_m} = '0;
		wstrb = 4'hF;
		foreach (on_m[i])
		begin
			on_m[i] = 1'b0;
			src_m[i] = 5'h00;
			adr_m[i] = 32'h0;
		end
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		// Reset state, unmapped and read-only places, all lines disabled
		per <= '1;
		wd <= 1'b1;
		rchk(`PIC_OFS_DEFAULT, 32'h0, PIC_RESP_OKAY);
		rchk(12'h300, 32'h0, PIC_RESP_SLVERR);
		wr(12'h300, 32'hFFFF_FFFF, r);
		chk({30'h0, r}, {30'h0, PIC_RESP_SLVERR});
		wr(`PIC_OFS_NSTAT, 32'hFFFF_FFFF, r);
		chk({30'h0, r}, {30'h0, PIC_RESP_OKAY});
		verify();
		$display("test reset done");
		// Watchdog fast, software channel in slot 0, channel 31 in slot 15
		en_m = 32'h8000_0003;
		sel_m = 32'h0000_0001;
		soft_m = 32'h0000_0002;
		def_m = 32'h0000_0D00;
		{on_m[0], src_m[0], adr_m[0]} = {1'b1, 5'h01, 32'h0000_0A00};
		{on_m[15], src_m[15], adr_m[15]} = {1'b1, 5'h1F, 32'h0000_0B00};
		apply();
		verify();
		// Slot 0 in service masks itself and slot 15 until the end write
		rchk(`PIC_OFS_VECT, 32'h0000_0A00, PIC_RESP_OKAY);
		rchk(`PIC_OFS_VECT, 32'h0000_0D00, PIC_RESP_OKAY);
		wr(`PIC_OFS_VECT, 32'h0, r);
		rchk(`PIC_OFS_VECT, 32'h0000_0A00, PIC_RESP_OKAY);
		wr(`PIC_OFS_VECT, 32'h0, r);
		// Byte lane write touches only byte 1 of the default address
		wstrb <= 4'h2;
		wr(`PIC_OFS_DEFAULT, 32'h1234_5678, r);
		wstrb <= 4'hF;
		def_m = 32'h0000_5600;
		rchk(`PIC_OFS_DEFAULT, def_m, PIC_RESP_OKAY);
		soft_m = 32'h0;
		apply();
		verify();
		// Channel 31 moved to fast while running
		per <= 30'h0000_0004;
		en_m = 32'h8000_0011;
		sel_m = 32'h8000_0000;
		apply();
		verify();
		per <= 30'h2000_0000;
		verify();
		$display("test corner done");
		for (int k = 0; k < 24; k++)
		begin
			per <= 30'($random(seed));
			wd <= 1'($random(seed));
			en_m = $random(seed);
			sel_m = $random(seed) & $random(seed);
			soft_m = $random(seed) & $random(seed) & $random(seed);
			def_m = $random(seed);
			for (int i = 0; i < 16; i++)
			begin
				src_m[i] = 5'($random(seed));
				on_m[i] = 1'($random(seed));
				adr_m[i] = $random(seed);
			end
			apply();
			verify();
		end
		$display("test random done");
		complete_run();
	end
endmodule
`default_nettype wire
